// *** pkg/srrc_map.svh ***
// command codes, checksum constants and data and checksum lengths of the reply block
`ifndef SRRC_MAP_SVH
`define SRRC_MAP_SVH

`define SRRC_CMD_FAN_RPM  8'h84
`define SRRC_CMD_FAN_DUTY 8'h85
`define SRRC_CMD_OP_MIN   8'h86
`define SRRC_CRC_SEED     16'hFFFF
`define SRRC_CRC_POLY     16'h8408
`define SRRC_CRC_ZERO     16'h0000
`define SRRC_LEN_SHORT    3'h2
`define SRRC_LEN_LONG     3'h4
`define SRRC_LEN_CHK      3'h2
`define SRRC_IDX_ZERO     3'h0
`define SRRC_IDX_ONE      3'h1

`endif

// *** pkg/srrc_pkg.sv ***
// types shared by the reply block
`default_nettype none
package srrc_pkg;
   typedef enum logic [3:0] {
      SRRC_IDLE = 4'h1,
      SRRC_CALC = 4'h2,
      SRRC_FIN  = 4'h4,
      SRRC_SEND = 4'h8
   } srrc_state_e;
   typedef logic [7:0] srrc_byte_t;
endpackage
`default_nettype wire

// *** logic/srrc_crc.sv ***
// byte-wide reflected 16-bit checksum generator
`timescale 1ns/1ps
`default_nettype none
`include "srrc_map.svh"

module srrc_crc (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic init_i,
   input wire logic en_i,
   input wire logic [7:0] data_i,
   output logic [15:0] chk_o
);
   logic [15:0] crc;
   logic [15:0] next_crc;

   // one whole byte per cycle, low bit first
   function automatic logic [15:0] srrc_step(input logic [15:0] c_in,
                                             input logic [7:0] d);
      logic [15:0] c;
      c = c_in;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ d[i]) begin
            c = (c >> 1) ^ `SRRC_CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   assign next_crc = srrc_step(crc, data_i);

   // init wins over en so a new reply never mixes with an old one
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc <= `SRRC_CRC_SEED;
      end else if (init_i) begin
         crc <= `SRRC_CRC_SEED;
      end else if (en_i) begin
         crc <= next_crc;
      end
   end

   assign chk_o = {~crc[7:0], ~crc[15:8]};

   crc_seed_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      init_i |=> crc == `SRRC_CRC_SEED)
      else $error("checksum not seeded with all ones");

   // seed inverted must read as zero, so a missing inversion shows at once
   crc_final_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      init_i |=> chk_o == `SRRC_CRC_ZERO)
      else $error("empty checksum not inverted");
endmodule
`default_nettype wire

// *** logic/srrc_reply.sv ***
// reply builder for fan speed, fan duty and operating minutes commands
//
// Contract
// - command 84h answers four bytes, fan rpm then the checksum high first.
// - command 85h answers four bytes, fan duty then the checksum high first.
// - command 86h answers six bytes, 32-bit minutes msb first then checksum.
// - the checksum starts at all ones and shifts each byte lsb first with 8408h.
// - the final checksum is the register inverted with its two bytes swapped.
`timescale 1ns/1ps
`default_nettype none
`include "srrc_map.svh"

module srrc_reply #(
   parameter int NBYTES = 6
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic byte_req_i,
   input wire logic [15:0] fan_rpm_i,
   input wire logic [15:0] fan_duty_i,
   input wire logic [31:0] op_minutes_i,
   output logic busy_o,
   output logic ready_o,
   output logic cmd_err_o,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic last_o
);
   ////////////////////////////////////////////////////////////////////////
   srrc_pkg::srrc_state_e state;
   srrc_pkg::srrc_state_e next_state;
   srrc_pkg::srrc_byte_t frame [0:NBYTES-1];
   logic [2:0] dlen;
   logic [2:0] cnt;
   logic [2:0] idx;
   logic [15:0] chk;
   wire is_rpm;
   wire is_duty;
   wire is_min;
   wire known;
   wire accept;
   wire feed;
   wire calc_done;
   wire fin;
   wire send;
   wire [2:0] load_len;
   wire [2:0] total;
   wire [47:0] load_word;

   // command decode
   assign is_rpm = cmd_code_i == `SRRC_CMD_FAN_RPM;
   assign is_duty = cmd_code_i == `SRRC_CMD_FAN_DUTY;
   assign is_min = cmd_code_i == `SRRC_CMD_OP_MIN;
   assign known = is_rpm | is_duty | is_min;
   // commands arriving while busy are dropped, not queued
   assign accept = cmd_valid_i && known && state == srrc_pkg::SRRC_IDLE;
   assign load_len = is_min ? `SRRC_LEN_LONG : `SRRC_LEN_SHORT;
   assign total = dlen + `SRRC_LEN_CHK;

   // rpm in the first two bytes, msb first
   // duty in the first two bytes, msb first
   // minutes msb first, lsb lands in the fourth byte
   assign load_word = is_min ? {op_minutes_i, 16'h0000} :
                      is_rpm ? {fan_rpm_i, 32'h0000_0000} :
                      {fan_duty_i, 32'h0000_0000};

   // sequencing strobes
   assign feed = state == srrc_pkg::SRRC_CALC;
   assign calc_done = feed && cnt == dlen - `SRRC_IDX_ONE;
   assign fin = state == srrc_pkg::SRRC_FIN;
   assign send = state == srrc_pkg::SRRC_SEND && byte_req_i;

   ////////////////////////////////////////////////////////////////////////
   // data bytes fed to the checksum one per cycle
   srrc_crc u_crc (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .init_i(accept),
      .en_i(feed),
      .data_i(frame[cnt]),
      .chk_o(chk)
   );

   // next state
   always_comb begin
      next_state = state;
      unique case (state)
         srrc_pkg::SRRC_IDLE: begin
            if (accept) next_state = srrc_pkg::SRRC_CALC;
         end
         srrc_pkg::SRRC_CALC: begin
            if (calc_done) next_state = srrc_pkg::SRRC_FIN;
         end
         srrc_pkg::SRRC_FIN: begin
            next_state = srrc_pkg::SRRC_SEND;
         end
         srrc_pkg::SRRC_SEND: begin
            if (send && idx == total - `SRRC_IDX_ONE) begin
               next_state = srrc_pkg::SRRC_IDLE;
            end
         end
         default: next_state = srrc_pkg::SRRC_IDLE;
      endcase
   end

   // state and status flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= srrc_pkg::SRRC_IDLE;
         busy_o <= 1'b0;
         ready_o <= 1'b0;
         cmd_err_o <= 1'b0;
      end else begin
         state <= next_state;
         busy_o <= next_state != srrc_pkg::SRRC_IDLE;
         ready_o <= next_state == srrc_pkg::SRRC_SEND;
         cmd_err_o <= cmd_valid_i && !known;
      end
   end

   // counters: cnt walks data bytes, idx walks sent bytes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dlen <= `SRRC_LEN_SHORT;
         cnt <= `SRRC_IDX_ZERO;
         idx <= `SRRC_IDX_ZERO;
      end else if (accept) begin
         dlen <= load_len;
         cnt <= `SRRC_IDX_ZERO;
         idx <= `SRRC_IDX_ZERO;
      end else begin
         if (feed) cnt <= cnt + `SRRC_IDX_ONE;
         if (send) idx <= idx + `SRRC_IDX_ONE;
      end
   end

   // frame storage; checksum bytes follow the data at fin
   generate
      for (genvar g = 0; g < NBYTES; g++) begin : g_frame
         localparam logic [2:0] POS = 3'(g);
         always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               frame[g] <= 8'h00;
            end else if (accept) begin
               frame[g] <= load_word[47-8*g -: 8];
            end else if (fin && POS == dlen) begin
               // swapped value sent high byte first
               frame[g] <= chk[15:8];
            end else if (fin && POS == dlen + `SRRC_IDX_ONE) begin
               frame[g] <= chk[7:0];
            end
         end
      end
   endgenerate

   // output byte, one request gives one byte the next cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_valid_o <= 1'b0;
         byte_o <= 8'h00;
         last_o <= 1'b0;
      end else begin
         byte_valid_o <= send;
         last_o <= send && idx == total - `SRRC_IDX_ONE;
         if (send) byte_o <= frame[idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_take_rpm;
      cmd_valid_i && cmd_code_i == `SRRC_CMD_FAN_RPM &&
         state == srrc_pkg::SRRC_IDLE;
   endsequence

   sequence s_take_min;
      cmd_valid_i && cmd_code_i == `SRRC_CMD_OP_MIN &&
         state == srrc_pkg::SRRC_IDLE;
   endsequence

   rpm_payload_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_take_rpm |=> frame[0] == $past(fan_rpm_i[15:8]) &&
         frame[1] == $past(fan_rpm_i[7:0]) && dlen == `SRRC_LEN_SHORT)
      else $error("rpm reply not loaded as four bytes");

   duty_payload_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd_valid_i && cmd_code_i == `SRRC_CMD_FAN_DUTY &&
         state == srrc_pkg::SRRC_IDLE |=>
         frame[1] == $past(fan_duty_i[7:0]) && total == 3'h4)
      else $error("duty reply not loaded as four bytes");

   min_length_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_take_min |=> frame[0] == $past(op_minutes_i[31:24]) &&
         total == 3'h6)
      else $error("minutes reply not six bytes");

   min_lsb_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_take_min |=> frame[3] == $past(op_minutes_i[7:0]))
      else $error("minutes lsb not in fourth byte");

   chk_place_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      fin |=> frame[dlen] == $past(chk[15:8]) &&
         frame[dlen + `SRRC_IDX_ONE] == $past(chk[7:0]))
      else $error("checksum bytes misplaced");

   crc_feed_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_take_min |=> feed [*4] ##1 fin ##1 ready_o)
      else $error("minutes data not fed four cycles");

   last_flag_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      last_o |-> byte_valid_o && $past(idx) == total - `SRRC_IDX_ONE)
      else $error("last flag at wrong byte");
endmodule
`default_nettype wire

// *** tb/srrc_host.sv ***
// host model that pulls reply bytes and assembles the checksum
`timescale 1ns/1ps
`default_nettype none
module srrc_host (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   input wire logic slow_i,
   input wire logic ready_i,
   input wire logic valid_i,
   input wire logic [7:0] byte_i,
   output logic req_o,
   output logic [7:0] rx_o [8],
   output logic [2:0] cnt_o,
   output logic [15:0] chk_o
);
   // one request a cycle, or every other cycle when stalling
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_o <= 1'b0;
         cnt_o <= 3'h0;
      end else begin
         req_o <= ready_i & ~(slow_i & req_o);
         if (clr_i)
            cnt_o <= 3'h0;
         else if (valid_i) begin
            rx_o[cnt_o] <= byte_i;
            cnt_o <= cnt_o + 3'h1;
         end
      end
   end
   // first byte times 256 plus second
   assign chk_o = {rx_o[cnt_o - 3'h2], rx_o[cnt_o - 3'h1]};
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the reply builder
`timescale 1ns/1ps
`default_nettype none
`include "srrc_map.svh"
module testbench;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_valid = 1'b0;
   logic clr = 1'b0;
   logic slow = 1'b0;
   logic [7:0] code = 8'h00;
   logic [15:0] rpm = 16'h1234;
   logic [15:0] duty = 16'h0042;
   logic [31:0] mins = 32'hA1B2C3D4;
   logic busy, ready, err, bval, last, req;
   logic [7:0] bdat;
   logic [7:0] rx [8];
   logic [2:0] cnt;
   logic [15:0] hchk;
   int errors = 0;
   int compares = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   srrc_reply u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .cmd_valid_i(cmd_valid), .cmd_code_i(code), .byte_req_i(req),
      .fan_rpm_i(rpm), .fan_duty_i(duty), .op_minutes_i(mins),
      .busy_o(busy), .ready_o(ready), .cmd_err_o(err),
      .byte_valid_o(bval), .byte_o(bdat), .last_o(last));
   srrc_host u_host (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clr_i(clr),
      .slow_i(slow), .ready_i(ready), .valid_i(bval), .byte_i(bdat),
      .req_o(req), .rx_o(rx), .cnt_o(cnt), .chk_o(hchk));
   // reflected shift from all ones, lsb first
   function automatic logic [15:0] crc16(logic [7:0] b [6], int n);
      logic [15:0] c;
      c = `SRRC_CRC_SEED;
      for (int j = 0; j < n; j++)
         for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[j][i]) ? (c >> 1) ^ `SRRC_CRC_POLY : c >> 1;
      c = ~c;
      return {c[7:0], c[15:8]};
   endfunction
   task automatic check(string name, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // data inputs change after the take edge: reply must keep old values
   task automatic run(logic [7:0] c, logic s, int lat, int n);
      int k;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      code <= c;
      slow <= s;
      clr <= 1'b1;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      clr <= 1'b0;
      rpm <= ~rpm;
      duty <= ~duty;
      mins <= ~mins;
      // ready rises at the edge lat-1 after the take edge
      repeat (lat - 2) @(posedge ref_clk_i);
      #1;
      check("busy", busy, 1);
      check("ready early", ready, 0);
      @(posedge ref_clk_i);
      #1;
      check("ready", ready, 1);
      k = 0;
      while (last !== 1'b1 && k < 40) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      if (k == 40) begin
         check("timeout", 1, 0);
         finish_test();
      end
      check("last valid", bval, 1);
      check("busy end", busy, 0);
      @(posedge ref_clk_i);
      #1;
      check("last end", last, 0);
      check("count", cnt, n);
   endtask
   task automatic t_rpm();
      logic [7:0] b [6];
      b = '{rpm[15:8], rpm[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
      run(`SRRC_CMD_FAN_RPM, 1'b0, 4, 4);
      check("rpm hi", rx[0], b[0]);
      check("rpm lo", rx[1], b[1]);
      check("rpm chk", hchk, crc16(b, 2));
   endtask
   task automatic t_duty();
      logic [7:0] b [6];
      b = '{duty[15:8], duty[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
      run(`SRRC_CMD_FAN_DUTY, 1'b1, 4, 4);
      check("duty hi", rx[0], b[0]);
      check("duty lo", rx[1], b[1]);
      check("duty chk", hchk, crc16(b, 2));
   endtask
   task automatic t_min();
      logic [7:0] b [6];
      b = '{mins[31:24], mins[23:16], mins[15:8], mins[7:0], 8'h00, 8'h00};
      run(`SRRC_CMD_OP_MIN, 1'b0, 6, 6);
      for (int i = 0; i < 3; i++)
         check("min byte", rx[i], b[i]);
      check("min lsb", rx[3], b[3]);
      check("min chk", hchk, crc16(b, 4));
   endtask
   // unknown code: error pulse only
   task automatic t_bad();
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      code <= 8'h00;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      // the error pulse stands only in the cycle after the take edge
      #1;
      check("err", err, 1);
      check("err busy", busy, 0);
      @(posedge ref_clk_i);
      #1;
      check("err end", err, 0);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_rpm();
      t_duty();
      t_min();
      t_bad();
      t_rpm();
      finish_test();
   end
endmodule
`default_nettype wire
